// ### logic/sac_top.sv
// Register file, clock selection and analog-side control of the SAR converter.
`timescale 1ns/10ps
module sac_top #(
	parameter int CHANNEL_COUNT = 8
) (
	// Clock and reset; ref_clk is the core oscillator clock.
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core state and the internal RC oscillator, both asynchronous pins here.
	input wire logic core_sleep,
	input wire logic rc_osc_in,
	// Analog side.
	input wire logic comp_hi_in,
	output logic [2:0] analog_channel_sel,
	output logic [7:0] dac_code,
	output logic sample_hold,
	output logic analog_power_en,
	output logic ext_reference_sel,
	output logic [7:0] pin_analog_en,
	// Interrupt and wake.
	output logic irq
);

	// Software-visible state.
	logic [1:0] clk_sel_ff;
	logic [2:0] chan_sel_ff;
	logic go_ff;
	logic power_on_ff;
	logic [2:0] pin_cfg_ff;
	logic [7:0] result_ff;
	logic irq_stat_ff;
	logic irq_mask_ff;

	// Synchronisers for pins outside the clock domain.
	logic [1:0] sleep_sync_ff;
	logic [1:0] rc_sync_ff;
	logic rc_prev_ff;
	logic [1:0] comp_sync_ff;

	// Conversion clock and captured channel.
	logic [4:0] div_cnt_ff;
	logic [4:0] div_last;
	logic div_tick;
	logic rc_tick;
	logic tad_tick;
	logic rc_mode;
	logic [2:0] held_chan_ff;

	// Bus decode and engine wiring.
	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic sw_start;
	logic sw_abort;
	logic sleep_abort;
	logic eng_abort;
	logic eng_busy;
	logic eng_done;
	logic eng_hold;
	logic [7:0] eng_code;
	logic sleep_now;
	logic [31:0] nxt_prdata;

	// True when the address names one of the five registers.
	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == sac_pkg::CTRL0_ADDR) || (addr == sac_pkg::PINCFG_ADDR)
			|| (addr == sac_pkg::RESULT_ADDR) || (addr == sac_pkg::IRQ_STAT_ADDR)
			|| (addr == sac_pkg::IRQ_MASK_ADDR);
	endfunction : is_mapped

	// Zero-wait slave: every access completes in its first access cycle.
	assign addr_hit = is_mapped(paddr);
	assign wr_en = psel && penable && pwrite && addr_hit;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// Two-flop synchronisers; only the second stage is read by logic.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sleep_sync_ff <= 2'b00;
			rc_sync_ff <= 2'b00;
			comp_sync_ff <= 2'b00;
			rc_prev_ff <= 1'b0;
		end else begin
			sleep_sync_ff <= {sleep_sync_ff[0], core_sleep};
			rc_sync_ff <= {rc_sync_ff[0], rc_osc_in};
			comp_sync_ff <= {comp_sync_ff[0], comp_hi_in};
			rc_prev_ff <= rc_sync_ff[1];
		end
	end

	assign sleep_now = sleep_sync_ff[1];

	// Divider ratio from the clock select field.
	always_comb begin
		unique case (clk_sel_ff)
			sac_pkg::CLK_DIV2: div_last = sac_pkg::DIV2_LAST; // R5
			sac_pkg::CLK_DIV8: div_last = sac_pkg::DIV8_LAST; // R5
			sac_pkg::CLK_DIV32: div_last = sac_pkg::DIV32_LAST; // R5
			sac_pkg::CLK_RC: div_last = sac_pkg::DIV32_LAST;
		endcase
	end

	// Divider of the core clock, held at zero while the engine is idle; restarts whenever the ratio is reached.
	always_ff @(posedge ref_clk) begin
		if (rst || !eng_busy) begin
			div_cnt_ff <= 5'h00;
		end else if (div_cnt_ff >= div_last) begin
			div_cnt_ff <= 5'h00;
		end else begin
			div_cnt_ff <= div_cnt_ff + 5'h01;
		end
	end

	// The RC oscillator keeps running while the core clock divider is idle in sleep.
	assign rc_mode = (clk_sel_ff == sac_pkg::CLK_RC); // R6
	assign div_tick = eng_busy && (div_cnt_ff >= div_last);
	assign rc_tick = rc_sync_ff[1] && !rc_prev_ff;
	assign tad_tick = rc_mode ? rc_tick : div_tick; // R6

	// A core-clocked conversion cannot survive sleep, so it is aborted on entry.
	assign sleep_abort = sleep_now && !rc_mode && go_ff; // R3

	// Software starts with a one written over a clear flag; a zero over a set flag aborts.
	assign sw_start = wr_en && (paddr == sac_pkg::CTRL0_ADDR) && pwdata[sac_pkg::GO_BIT]
		&& !go_ff && power_on_ff && !(sleep_now && !rc_mode); // R8
	assign sw_abort = wr_en && (paddr == sac_pkg::CTRL0_ADDR) && !pwdata[sac_pkg::GO_BIT] && go_ff;
	assign eng_abort = sw_abort || sleep_abort || !power_on_ff;

	sac_sar_engine u_engine (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(sw_start),
		.abort(eng_abort),
		.tad_tick(tad_tick),
		.rc_mode(rc_mode),
		.comp_hi(comp_sync_ff[1]),
		.busy(eng_busy),
		.done(eng_done),
		.hold_ff(eng_hold),
		.dac_code_ff(eng_code),
		.result_ff()
	);

	// Operation control fields; the go flag is cleared by hardware on completion.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_sel_ff <= sac_pkg::CLK_SEL_RST; // R12
			chan_sel_ff <= sac_pkg::CHAN_SEL_RST; // R12
			power_on_ff <= 1'b0; // R12
		end else if (wr_en && (paddr == sac_pkg::CTRL0_ADDR)) begin
			clk_sel_ff <= pwdata[sac_pkg::CLK_SEL_LSB +: 2]; // R5
			chan_sel_ff <= pwdata[sac_pkg::CHAN_SEL_LSB +: 3]; // R7
			power_on_ff <= pwdata[sac_pkg::POWER_BIT]; // R10
		end
	end

	// Completion wins over a same-cycle write, since the flag must fall with the result load.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			go_ff <= 1'b0; // R12
		end else if (eng_done || eng_abort) begin
			go_ff <= 1'b0; // R9
		end else if (sw_start) begin
			go_ff <= 1'b1; // R8
		end
	end

	// Result register: loaded on completion, otherwise writable by software.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_ff <= sac_pkg::RESULT_RST;
		end else if (eng_done) begin
			result_ff <= eng_code; // R9 The engine copy lands on this same edge with the same code.
		end else if (wr_en && (paddr == sac_pkg::RESULT_ADDR)) begin
			result_ff <= pwdata[7:0];
		end
	end

	// Pin configuration register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_cfg_ff <= sac_pkg::PINCFG_RST; // R12
		end else if (wr_en && (paddr == sac_pkg::PINCFG_ADDR)) begin
			pin_cfg_ff <= pwdata[2:0]; // R14
		end
	end

	// Completion status: write one to clear, but a same-cycle completion keeps it set.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_stat_ff <= 1'b0;
		end else if (eng_done) begin
			irq_stat_ff <= 1'b1;
		end else if (wr_en && (paddr == sac_pkg::IRQ_STAT_ADDR) && pwdata[0]) begin
			irq_stat_ff <= 1'b0;
		end
	end

	// Interrupt mask; a set bit lets the status reach the output.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_mask_ff <= 1'b0;
		end else if (wr_en && (paddr == sac_pkg::IRQ_MASK_ADDR)) begin
			irq_mask_ff <= pwdata[0];
		end
	end

	assign irq = irq_stat_ff && irq_mask_ff;

	// The channel is latched at start so a later select write cannot disturb the held sample.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			held_chan_ff <= 3'h0;
		end else if (sw_start) begin
			held_chan_ff <= chan_sel_ff; // R15
		end
	end

	// Channels beyond the implemented count select nothing useful; the low bits still route.
	assign analog_channel_sel = go_ff ? held_chan_ff : chan_sel_ff; // R7 R4
	assign dac_code = eng_code;
	assign sample_hold = eng_hold;

	// Analog bias is cut when powered down or when the core sleeps with a core-derived clock selected.
	assign analog_power_en = power_on_ff && !(sleep_now && !rc_mode); // R10 R3

	// Odd configuration codes other than 7 take the reference from the external reference pin.
	assign ext_reference_sel = pin_cfg_ff[0] && (pin_cfg_ff[2:1] != 2'b11); // R2 R14

	// Analog enables per pin: bits 0-4 are port A pins, 5-7 the extra channels.
	always_comb begin
		logic [7:0] en;
		en = 8'h00;
		unique case (pin_cfg_ff[2:1])
			2'b00: en = 8'hFF; // R14
			2'b01: en = 8'h1F; // R14
			2'b10: en = 8'h0B; // R14
			2'b11: en = 8'h00; // R14
		endcase
		if (ext_reference_sel) begin
			en[3] = 1'b0;
		end
		if (CHANNEL_COUNT < 8) begin
			en[7:5] = 3'b000; // R4
		end
		pin_analog_en = en;
	end

	// Read mux; the unimplemented control bit always reads zero.
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			sac_pkg::CTRL0_ADDR: begin
				nxt_prdata[7:0] = {clk_sel_ff, chan_sel_ff, go_ff, 1'b0, power_on_ff}; // R11 R13
			end
			sac_pkg::PINCFG_ADDR: nxt_prdata[2:0] = pin_cfg_ff; // R13
			sac_pkg::RESULT_ADDR: nxt_prdata[7:0] = result_ff; // R13
			sac_pkg::IRQ_STAT_ADDR: nxt_prdata[0] = irq_stat_ff;
			sac_pkg::IRQ_MASK_ADDR: nxt_prdata[0] = irq_mask_ff;
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// Read data come from a flop loaded during the setup cycle, valid in the access cycle.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= nxt_prdata;
		end else if (rd_en) begin
			prdata <= prdata;
		end
	end

endmodule : sac_top

// ### logic/sac_pkg.sv
// Package of constants and types shared by the converter control block.
// Contract
// (R1) The converter turns the held analog level into an 8-bit result by successive approximation.
// (R2) Software chooses the reference: the positive supply or the external reference pin.
// (R3) Conversion during core sleep works only with the internal RC oscillator as clock.
// (R4) The number of analog channels is a parameter: five on the small part, eight on the large.
// (R5) Clock select bits 7:6 give the core clock divided by 2 (00), by 8 (01) or by 32 (10).
// (R6) Clock select value 11 picks the internal RC oscillator, the only choice usable in sleep.
// (R7) Channel select bits 5:3 route channel 0 to 7 in binary order to the sample-and-hold.
// (R8) Writing one to bit 2 starts a conversion and hardware clears it when the result is ready.
// (R9) On completion the flag clears and the result register loads in the same update.
// (R10) Clearing the power bit 0 puts the converter into its lowest-consumption state.
// (R11) Bit 1 of the control register ignores writes and reads zero.
// (R12) Every implemented control field is read/write and resets to zero.
// (R13) There are three software registers: result, operation control and pin configuration; the code adds interrupt status and mask, five in all.
// (R14) The pin configuration register sets each shared pin analog or digital and one as reference.
// (R15) The selected channel is captured at start and held until every result bit is decided.
package sac_pkg;

	// Register indices; the bus byte address is four times the index.
	localparam logic [9:0] CTRL0_IDX = 10'h01F;
	localparam logic [9:0] PINCFG_IDX = 10'h09F;
	localparam logic [9:0] RESULT_IDX = 10'h01E;
	localparam logic [9:0] IRQ_STAT_IDX = 10'h020;
	localparam logic [9:0] IRQ_MASK_IDX = 10'h021;
	localparam logic [11:0] CTRL0_ADDR = {CTRL0_IDX, 2'b00};
	localparam logic [11:0] PINCFG_ADDR = {PINCFG_IDX, 2'b00};
	localparam logic [11:0] RESULT_ADDR = {RESULT_IDX, 2'b00};
	localparam logic [11:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'b00};
	localparam logic [11:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

	// Field positions in the operation control register.
	localparam int CLK_SEL_LSB = 6;
	localparam int CHAN_SEL_LSB = 3;
	localparam int GO_BIT = 2;
	localparam int POWER_BIT = 0;

	// Reset values.
	localparam logic [1:0] CLK_SEL_RST = 2'h0;
	localparam logic [2:0] CHAN_SEL_RST = 3'h0;
	localparam logic [2:0] PINCFG_RST = 3'h0;
	localparam logic [7:0] RESULT_RST = 8'h00;

	// Clock select encodings.
	localparam logic [1:0] CLK_DIV2 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV32 = 2'h2;
	localparam logic [1:0] CLK_RC = 2'h3;

	// Divider terminal counts, one less than the divide ratio.
	localparam logic [4:0] DIV2_LAST = 5'h01;
	localparam logic [4:0] DIV8_LAST = 5'h07;
	localparam logic [4:0] DIV32_LAST = 5'h1F;

	// Result width and the index of the first trial bit.
	localparam int RES_W = 8;
	localparam logic [2:0] MSB_IDX = 3'h7;

	// Engine states.
	typedef enum logic [2:0] {
		SAC_IDLE,
		SAC_DELAY,
		SAC_SAMPLE,
		SAC_CONVERT,
		SAC_FINISH
	} sac_state_t;

endpackage : sac_pkg

// ### logic/sac_sar_engine.sv
// Successive-approximation sequencer stepped by conversion clock ticks.
`timescale 1ns/10ps
module sac_sar_engine (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Control from the register side.
	input wire logic start,
	input wire logic abort,
	input wire logic tad_tick,
	input wire logic rc_mode,
	// Synchronised comparator: high when the input is at or above the trial level.
	input wire logic comp_hi,
	// Status and data.
	output logic busy,
	output logic done,
	output logic hold_ff,
	output logic [7:0] dac_code_ff,
	output logic [7:0] result_ff
);

	sac_pkg::sac_state_t state_ff;
	logic [2:0] bit_idx_ff;

	// One-hot mask of the bit now under trial.
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	assign busy = (state_ff != sac_pkg::SAC_IDLE);
	assign done = (state_ff == sac_pkg::SAC_FINISH) && tad_tick && !abort;

	// Sequencer; in RC mode one extra tick lets the core enter sleep before sampling.
	always_ff @(posedge ref_clk) begin
		if (rst || abort) begin
			state_ff <= sac_pkg::SAC_IDLE;
			hold_ff <= 1'b0;
			bit_idx_ff <= sac_pkg::MSB_IDX;
			dac_code_ff <= 8'h00;
		end else begin
			unique case (state_ff)
				sac_pkg::SAC_IDLE: begin
					if (start) begin
						state_ff <= rc_mode ? sac_pkg::SAC_DELAY : sac_pkg::SAC_SAMPLE;
					end
				end
				sac_pkg::SAC_DELAY: begin
					if (tad_tick) begin
						state_ff <= sac_pkg::SAC_SAMPLE;
					end
				end
				sac_pkg::SAC_SAMPLE: begin
					if (tad_tick) begin
						state_ff <= sac_pkg::SAC_CONVERT;
						hold_ff <= 1'b1; // R15
						bit_idx_ff <= sac_pkg::MSB_IDX;
						dac_code_ff <= bit_mask(sac_pkg::MSB_IDX);
					end
				end
				sac_pkg::SAC_CONVERT: begin
					// Keep or drop the trial bit, then try the next lower one.
					if (tad_tick) begin
						if (bit_idx_ff == 3'h0) begin
							state_ff <= sac_pkg::SAC_FINISH;
							dac_code_ff <= comp_hi ? dac_code_ff : (dac_code_ff & ~bit_mask(3'h0)); // R1
						end else begin
							dac_code_ff <= (comp_hi ? dac_code_ff : (dac_code_ff & ~bit_mask(bit_idx_ff)))
								| bit_mask(bit_idx_ff - 3'h1); // R1
							bit_idx_ff <= bit_idx_ff - 3'h1;
						end
					end
				end
				sac_pkg::SAC_FINISH: begin
					if (tad_tick) begin
						state_ff <= sac_pkg::SAC_IDLE;
						hold_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	// Completed code; an aborted run never reaches here.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_ff <= sac_pkg::RESULT_RST;
		end else if (done) begin
			result_ff <= dac_code_ff;
		end
	end

endmodule : sac_sar_engine

// ### dv/sac_chk.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/10ps
module sac_chk #(
	parameter int CHANNEL_COUNT = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Analog side and interrupt.
	input wire logic [2:0] analog_channel_sel,
	input wire logic sample_hold,
	input wire logic analog_power_en,
	input wire logic ext_reference_sel,
	input wire logic [7:0] pin_analog_en,
	input wire logic irq
);
	logic [2:0] cfg_ff;
	logic pwr_ff;
	logic mask_ff;
	logic mapped;
	logic [2:0] wsel;
	logic [7:0] pins_exp;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Shadows land on the same write edge as the design registers, so no skew to allow for.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_ff <= 3'h0;
			pwr_ff <= 1'b0;
			mask_ff <= 1'b0;
		end else if (psel && penable && pwrite) begin
			cfg_ff <= (paddr == sac_pkg::PINCFG_ADDR) ? pwdata[2:0] : cfg_ff;
			pwr_ff <= (paddr == sac_pkg::CTRL0_ADDR) ? pwdata[0] : pwr_ff;
			mask_ff <= (paddr == sac_pkg::IRQ_MASK_ADDR) ? pwdata[0] : mask_ff;
		end
	end

	// Address decode, write channel field and expected analog pin pattern.
	assign mapped = paddr inside {sac_pkg::CTRL0_ADDR, sac_pkg::PINCFG_ADDR,
		sac_pkg::RESULT_ADDR, sac_pkg::IRQ_STAT_ADDR, sac_pkg::IRQ_MASK_ADDR};
	assign wsel = pwdata[5:3];
	always_comb begin
		case (cfg_ff)
			3'h0: pins_exp = 8'hFF;
			3'h1: pins_exp = 8'hF7;
			3'h2: pins_exp = 8'h1F;
			3'h3: pins_exp = 8'h17;
			3'h4: pins_exp = 8'h0B;
			3'h5: pins_exp = 8'h03;
			default: pins_exp = 8'h00;
		endcase
		if (CHANNEL_COUNT == 5) begin
			pins_exp = pins_exp & 8'h1F;
		end
	end

	// Setup then access of a control register write or read.
	sequence wr_ctrl_s;
		psel && !penable && pwrite && paddr == sac_pkg::CTRL0_ADDR ##1 psel && penable;
	endsequence
	sequence rd_ctrl_s;
		psel && !penable && !pwrite && paddr == sac_pkg::CTRL0_ADDR ##1 psel && penable;
	endsequence

	unmapped_err_a: assert property (
		psel && penable && !mapped |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access without error response");
	bit1_zero_a: assert property (
		rd_ctrl_s |-> prdata[1] == 1'b0 && prdata[31:8] == 24'h00_0000)
		else $error("control read shows unimplemented bits");
	go_busy_a: assert property (
		rd_ctrl_s ##0 sample_hold |-> prdata[2])
		else $error("status flag low while holding a sample");
	reset_quiet_a: assert property (
		$fell(rst) |-> !irq && !sample_hold && !analog_power_en && pin_analog_en == pins_exp)
		else $error("outputs not quiet after reset");
	power_off_a: assert property (
		analog_power_en |-> pwr_ff)
		else $error("converter powered with power bit clear");
	chan_live_a: assert property (
		wr_ctrl_s ##0 !pwdata[2] |=> analog_channel_sel == $past(wsel))
		else $error("channel select does not follow the field");
	chan_hold_a: assert property (
		sample_hold ##1 sample_hold |-> $stable(analog_channel_sel))
		else $error("channel moved while sample held");
	ext_ref_a: assert property (
		ext_reference_sel == (cfg_ff[0] && cfg_ff[2:1] != 2'h3))
		else $error("reference choice wrong");
	pin_cfg_a: assert property (
		pin_analog_en == pins_exp)
		else $error("analog pin pattern wrong");
	irq_mask_a: assert property (
		irq |-> mask_ff)
		else $error("interrupt raised while masked");
endmodule : sac_chk

bind sac_top sac_chk #(.CHANNEL_COUNT(CHANNEL_COUNT)) u_sac_chk (
	.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.analog_channel_sel(analog_channel_sel), .sample_hold(sample_hold),
	.analog_power_en(analog_power_en), .ext_reference_sel(ext_reference_sel),
	.pin_analog_en(pin_analog_en), .irq(irq)
);

// ### dv/sac_analog_model.sv
// Behavioural model of the analog channels, comparator and internal RC oscillator.
`timescale 1ns/10ps
module sac_analog_model (
	// Clock.
	input wire logic ref_clk,
	// Converter side.
	input wire logic [2:0] analog_channel_sel,
	input wire logic [7:0] dac_code,
	input wire logic sample_hold,
	input wire logic analog_power_en,
	// Channel n level in bits 8n+7:8n.
	input wire logic [63:0] levels,
	// Comparator and oscillator.
	output logic comp_hi_in,
	output logic rc_osc_in
);
	logic [7:0] held;
	logic tog;

	// The hold capacitor tracks the routed channel and freezes while the hold is closed.
	always @(posedge ref_clk) begin
		if (!sample_hold) begin
			held <= levels[8 * analog_channel_sel +: 8];
		end
		tog <= ~tog;
	end

	// A powered-down comparator gives no useful answer, so it chatters instead of idling.
	assign comp_hi_in = analog_power_en ? (held >= dac_code) : tog;

	// Free-running RC source, deliberately unrelated to the core clock.
	initial begin
		tog = 1'b0;
		rc_osc_in = 1'b0;
		forever #42.3 rc_osc_in = ~rc_osc_in;
	end
endmodule : sac_analog_model

// ### dv/tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module tb_top;
	logic ref_clk, rst, psel, penable, pwrite, core_sleep, err;
	logic pready, pslverr, rc_osc_in, comp_hi_in, sample_hold, analog_power_en;
	logic ext_reference_sel, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, rnd, w;
	logic [2:0] analog_channel_sel;
	logic [7:0] dac_code, pin_analog_en, lv, pins_small;
	logic [63:0] levels;
	int num_errors, n_checks, cyc, dur, t0;
	int pin_tab[8] = '{255, 247, 31, 23, 11, 3, 0, 0};
	int div_tab[4] = '{2, 8, 32, 17};
	logic [11:0] regs[5] = '{sac_pkg::CTRL0_ADDR, sac_pkg::PINCFG_ADDR, sac_pkg::RESULT_ADDR,
		sac_pkg::IRQ_STAT_ADDR, sac_pkg::IRQ_MASK_ADDR};

	sac_top #(.CHANNEL_COUNT(8)) dut (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_sleep(core_sleep), .rc_osc_in(rc_osc_in), .comp_hi_in(comp_hi_in),
		.analog_channel_sel(analog_channel_sel), .dac_code(dac_code),
		.sample_hold(sample_hold), .analog_power_en(analog_power_en),
		.ext_reference_sel(ext_reference_sel), .pin_analog_en(pin_analog_en), .irq(irq)
	);
	// Five-channel variant on the same bus; only its pin enables are compared.
	sac_top #(.CHANNEL_COUNT(5)) dut_small (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.core_sleep(core_sleep), .rc_osc_in(rc_osc_in), .comp_hi_in(comp_hi_in),
		.analog_channel_sel(), .dac_code(), .sample_hold(), .analog_power_en(),
		.ext_reference_sel(), .pin_analog_en(pins_small), .irq()
	);
	sac_analog_model pm (
		.ref_clk(ref_clk), .analog_channel_sel(analog_channel_sel), .dac_code(dac_code),
		.sample_hold(sample_hold), .analog_power_en(analog_power_en), .levels(levels),
		.comp_hi_in(comp_hi_in), .rc_osc_in(rc_osc_in)
	);

	// Core clock and a cycle count for conversion timing.
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	endfunction : xs

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
		end
	endtask : chk_rng

	// Setup, access until ready, then release; an idle edge follows so calls can chain.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for ready, so a stuck slave fails the run.
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0000);
		chk(q, exp);
	endtask : rd_chk

	// Power up on a clock and channel, start, then poll the flag until it clears.
	task automatic conv(input logic [1:0] s, input logic [2:0] ch);
		w = {24'h00_0000, s, ch, 3'h1};
		apb(1'b1, sac_pkg::CTRL0_ADDR, w);
		chk(analog_power_en, 32'h1);
		apb(1'b1, sac_pkg::CTRL0_ADDR, w | 32'h4);
		t0 = cyc;
		rd_chk(sac_pkg::CTRL0_ADDR, w | 32'h4);
		do begin
			apb(1'b0, sac_pkg::CTRL0_ADDR, 32'h0000_0000);
		end while (q[2] === 1'b1 && cyc - t0 < 2000);
		dur = cyc - t0;
		chk(q, w);
	endtask : conv

	task automatic close_out;
		$display("Checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// A run needs under two thousand cycles; this margin only catches a hang.
	initial begin
		#200000;
		num_errors++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, core_sleep} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		levels = 64'h0;
		rnd = 32'h0001_0A03;
		{num_errors, n_checks, cyc} = {32'd0, 32'd0, 32'd0};
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000);
		chk(pin_analog_en, 32'hFF);
		chk(pins_small, 32'h1F);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'hFFFF_FFFF);
		rd_chk(sac_pkg::CTRL0_ADDR, 32'hF9);
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'h0000_0000);
		chk(analog_power_en, 32'h0);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, sac_pkg::PINCFG_ADDR, c);
			rd_chk(sac_pkg::PINCFG_ADDR, c);
			chk(pin_analog_en, pin_tab[c]);
			chk(pins_small, pin_tab[c] & 32'h1F);
			chk(ext_reference_sel, c % 2 == 1 && c < 6);
		end
		apb(1'b1, sac_pkg::PINCFG_ADDR, 32'h0000_0000);
		// Every clock choice; the divide-by-32 pass also checks a masked interrupt.
		for (int s = 0; s < 4; s++) begin
			rnd = xs(rnd);
			levels <= {rnd, xs(rnd)};
			apb(1'b1, sac_pkg::IRQ_MASK_ADDR, {31'h0, s != 2});
			conv(2'(s), rnd[10:8]);
			lv = levels[8 * rnd[10:8] +: 8];
			chk_rng(dur, (9 + s / 3) * div_tab[s], (11 + s / 3) * div_tab[s] + 8);
			if (s != 0) rd_chk(sac_pkg::RESULT_ADDR, lv);
			if (s != 0) chk(dac_code, lv);
			rd_chk(sac_pkg::IRQ_STAT_ADDR, 32'h1);
			chk(irq, s != 2);
			apb(1'b1, sac_pkg::IRQ_MASK_ADDR, 32'h1);
			chk(irq, 32'h1);
			apb(1'b1, sac_pkg::IRQ_STAT_ADDR, 32'h1);
			chk(irq, 32'h0);
		end
		// Abort mid-way at divide-by-32; wait past a full conversion of 10 periods.
		levels <= ~levels;
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'h89);
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'h8D);
		repeat (60) @(posedge ref_clk);
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'h89);
		repeat (400) @(posedge ref_clk);
		rd_chk(sac_pkg::CTRL0_ADDR, 32'h89);
		rd_chk(sac_pkg::RESULT_ADDR, lv);
		rd_chk(sac_pkg::IRQ_STAT_ADDR, 32'h0);
		// Asleep: a divided clock refuses to start, the RC clock converts.
		core_sleep <= 1'b1;
		repeat (3) @(posedge ref_clk);
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'h49);
		apb(1'b1, sac_pkg::CTRL0_ADDR, 32'h4D);
		rd_chk(sac_pkg::CTRL0_ADDR, 32'h49);
		chk(analog_power_en, 32'h0);
		conv(2'h3, 3'h5);
		rd_chk(sac_pkg::RESULT_ADDR, levels[47:40]);
		core_sleep <= 1'b0;
		apb(1'b1, sac_pkg::PINCFG_ADDR, 32'h5);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd_chk(sac_pkg::PINCFG_ADDR, 32'h0000_0000);
		rd_chk(sac_pkg::CTRL0_ADDR, 32'h0000_0000);
		close_out();
	end
endmodule : tb_top
